/* File: hdl/plc_link_cmd.sv */
// What this block does
// - main and sub program batch reads decoded, up to 128 bytes each.
// - main and sub program batch writes decoded, up to 128 bytes each.
// - program addresses arrive as four ASCII hex digits, converted to binary.
// - program addresses bounded by configured capacity, at most E7FEH.
// - program access whose last byte is at or past capacity answers error 06H.
// - comment memory batch read and write decoded, up to 128 bytes.
// - comment addresses are four ASCII hex digits from zero, 64K max.
// - comment access with start plus count over capacity answers 06H.
// - extension comment read/write decoded; write refused while running without permit.
// - extension addresses are five ASCII hex digits, 00000 to 0FBFF.
// - extension access errors 06H when capacity below start plus count minus one.
// - broadcast command sets or clears the global input flag.
// - station 00H hits every station, other numbers only the match.
// - broadcast command gets no reply.
// - global input flag cleared by reset.
// - busy flag rises at once on send request, drops when sent.
// - send error writes 1 to the error word, 0 means none.
// - send request during a reply waits until the reply is out.
// - reply to a command is deferred until the spontaneous send ends.
// - on half duplex, send waits until the command is fully received.
// - echo test returns received characters unchanged, up to 254.
`timescale 1ns/1ps
`default_nettype none
`include "plc_link_map.svh"
module plc_link_cmd
	import plc_link_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_last,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	output logic             tx_last,
	input  wire logic        tx_ready,
	input  wire logic        tx_error,
	input  wire logic        full_duplex_pin,
	input  wire logic        cpu_running_pin,
	input  wire logic        run_write_permit_switch,
	input  wire logic [7:0]  station_pin,
	input  wire logic [16:0] micro_cap,
	input  wire logic [16:0] comment_cap,
	input  wire logic [16:0] ext_cap,
	output logic             mem_rd,
	output logic             mem_we,
	output logic [2:0]       mem_space,
	output logic [19:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	input  wire logic [15:0] mem_rdata,
	input  wire logic [11:0] bm_addr,
	input  wire logic        bm_wr,
	input  wire logic        bm_rd,
	input  wire logic [15:0] bm_wdata,
	output logic [15:0]      bm_rdata,
	input  wire logic        od_request,
	output logic             global_input_flag,
	output logic             ondemand_busy_flag
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [10:0] pin_m_q;
	logic [10:0] pin_s_q;
	logic        full_q;
	logic        run_q;
	logic        permit_q;
	logic [7:0]  stn_id;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_m_q <= '0;
			pin_s_q <= '0;
		end else if (ce) begin
			pin_m_q <= {full_duplex_pin, cpu_running_pin, run_write_permit_switch, station_pin};
			pin_s_q <= pin_m_q;
		end
	end
	assign {full_q, run_q, permit_q, stn_id} = pin_s_q;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) begin
			hex_val = {1'b1, 4'(c - 8'h30)};
		end else if (c >= 8'h41 && c <= 8'h46) begin
			hex_val = {1'b1, 4'(c - 8'h37)};
		end else begin
			hex_val = 5'h00;
		end
	endfunction

	function automatic logic area_ok(input logic [2:0] sp, input logic [19:0] a,
			input logic [7:0] n, input logic [16:0] cap);
		logic [20:0] sum;
		sum = 21'(a) + 21'(n);
		if (sp == `PLC_SP_EXT) begin
			area_ok = (21'(cap) >= 21'(sum - 21'd1)) && (a <= `PLC_EXT_ADDR_MAX);
		end else begin
			area_ok = sum <= 21'(cap);
		end
	endfunction

	// ****************************************
	// command parser
	// ****************************************
	plc_pst_t    pst_q;
	plc_op_t     op_q;
	logic [2:0]  space_q;
	logic [2:0]  dig_q;
	logic [2:0]  ndig_q;
	logic [7:0]  stn_q;
	logic [7:0]  c0_q;
	logic [19:0] addr_q;
	logic [7:0]  cnt_q;
	logic [7:0]  nrx_q;
	logic [3:0]  hi_q;
	logic        half_q;
	logic [7:0]  err_q;
	logic        gval_q;
	logic        gset_q;
	logic        done_q;
	logic        rx_act_q;
	logic [7:0]  buf_q [256];
	logic        resp_take;
	logic        take;
	logic [4:0]  hx;
	logic [16:0] cap;

	assign take = ce && rx_valid && !done_q;
	assign hx   = hex_val(rx_data);
	assign cap  = (space_q == `PLC_SP_COMMENT) ? comment_cap :
	              (space_q == `PLC_SP_EXT) ? ext_cap : micro_cap;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_act_q <= 1'b0;
		end else if (take) begin
			rx_act_q <= !rx_last;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pst_q   <= P_STN;
			op_q    <= OP_NONE;
			space_q <= `PLC_SP_MICRO_MAIN;
			dig_q   <= '0;
			ndig_q  <= `PLC_DIG_SHORT;
			stn_q   <= '0;
			c0_q    <= '0;
			addr_q  <= '0;
			cnt_q   <= '0;
			nrx_q   <= '0;
			hi_q    <= '0;
			half_q  <= 1'b0;
			err_q   <= `PLC_RSP_OK;
			gval_q  <= 1'b0;
			gset_q  <= 1'b0;
			done_q  <= 1'b0;
		end else if (ce) begin
			if (resp_take) begin
				done_q <= 1'b0;
			end
			if (take) begin
				dig_q <= 3'(dig_q + 1'b1);
				case (pst_q)
					P_STN: begin
						if (dig_q == 3'h0) begin
							err_q  <= hx[4] ? `PLC_RSP_OK : `PLC_RSP_AREA_ERR;
							gval_q <= 1'b0;
							nrx_q  <= '0;
							addr_q <= '0;
							cnt_q  <= '0;
							half_q <= 1'b0;
						end else begin
							pst_q <= P_CMD;
							dig_q <= '0;
							if (!hx[4]) begin
								err_q <= `PLC_RSP_AREA_ERR;
							end
						end
						stn_q <= {stn_q[3:0], hx[3:0]};
					end
					P_CMD: begin
						c0_q <= rx_data;
						if (dig_q == 3'h1) begin
							dig_q <= '0;
							pst_q <= P_ADDR;
							op_q  <= (rx_data == `PLC_CH_READ) ? OP_RD : OP_WR;
							ndig_q <= `PLC_DIG_SHORT;
							case (c0_q)
								`PLC_CH_MICRO_MAIN: space_q <= `PLC_SP_MICRO_MAIN;
								`PLC_CH_MICRO_SUB:  space_q <= `PLC_SP_MICRO_SUB;
								`PLC_CH_COMMENT:    space_q <= `PLC_SP_COMMENT;
								`PLC_CH_EXT: begin
									space_q <= `PLC_SP_EXT;
									ndig_q  <= `PLC_DIG_LONG;
									if (rx_data == `PLC_CH_WRITE && run_q && !permit_q) begin
										err_q <= `PLC_RSP_REJECT;
									end
								end
								default: space_q <= `PLC_SP_MICRO_MAIN;
							endcase
							if (c0_q == `PLC_CH_GLOBAL && rx_data == `PLC_CH_WRITE) begin
								op_q  <= OP_GLOBAL;
								pst_q <= P_GFLAG;
							end else if (c0_q == `PLC_CH_ECHO && rx_data == `PLC_CH_ECHO) begin
								op_q  <= OP_ECHO;
								pst_q <= P_CNT;
							end else if ((rx_data != `PLC_CH_READ && rx_data != `PLC_CH_WRITE)
									|| !(c0_q inside {`PLC_CH_MICRO_MAIN, `PLC_CH_MICRO_SUB,
									`PLC_CH_COMMENT, `PLC_CH_EXT})) begin
								err_q <= `PLC_RSP_AREA_ERR;
								pst_q <= P_SKIP;
							end
						end
					end
					P_ADDR: begin
						addr_q <= {addr_q[15:0], hx[3:0]};
						if (!hx[4]) begin
							err_q <= `PLC_RSP_AREA_ERR;
						end
						if (dig_q == 3'(ndig_q - 1'b1)) begin
							dig_q <= '0;
							pst_q <= P_CNT;
						end
					end
					P_CNT: begin
						cnt_q <= {cnt_q[3:0], hx[3:0]};
						if (!hx[4]) begin
							err_q <= `PLC_RSP_AREA_ERR;
						end
						if (dig_q == 3'(`PLC_DIG_CNT - 1'b1)) begin
							dig_q <= '0;
							pst_q <= P_DATA;
							if (op_q == OP_ECHO) begin
								if ({cnt_q[3:0], hx[3:0]} > `PLC_MAX_ECHO) begin
									err_q <= `PLC_RSP_AREA_ERR;
								end
							end else if ({cnt_q[3:0], hx[3:0]} == 8'h00
									|| {cnt_q[3:0], hx[3:0]} > `PLC_MAX_BYTES
									|| !area_ok(space_q, addr_q, {cnt_q[3:0], hx[3:0]}, cap)) begin
								err_q <= `PLC_RSP_AREA_ERR;
							end
						end
					end
					P_DATA: begin
						if (op_q == OP_ECHO) begin
							buf_q[nrx_q] <= rx_data;
							nrx_q        <= 8'(nrx_q + 1'b1);
						end else begin
							half_q <= !half_q;
							hi_q   <= hx[3:0];
							if (half_q) begin
								buf_q[nrx_q] <= {hi_q, hx[3:0]};
								nrx_q        <= 8'(nrx_q + 1'b1);
							end
						end
					end
					P_GFLAG: begin
						gval_q <= 1'b1;
						gset_q <= (rx_data == `PLC_CH_ONE);
						pst_q  <= P_SKIP;
					end
					default: begin
					end
				endcase
				if (rx_last) begin
					pst_q  <= P_STN;
					dig_q  <= '0;
					// only a matching unicast command earns a reply
					done_q <= (op_q != OP_GLOBAL) && (stn_q == stn_id)
					          && (pst_q != P_STN) && (pst_q != P_CMD);
				end
			end
		end
	end

	// ****************************************
	// global input flag
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			global_input_flag <= 1'b0;
		end else if (take && rx_last && op_q == OP_GLOBAL
				&& (pst_q == P_GFLAG || (pst_q == P_SKIP && gval_q))) begin
			if (stn_q == `PLC_STN_ALL || stn_q == stn_id) begin
				// flag char may itself close the frame
				global_input_flag <= (pst_q == P_GFLAG) ? (rx_data == `PLC_CH_ONE)
				                     : gset_q;
			end
		end
	end

	// ****************************************
	// buffer memory words
	// ****************************************
	logic [15:0] od_start_q;
	logic [15:0] od_len_q;
	logic [15:0] od_err_q;
	plc_seq_t    seq_q;
	logic        ret_rd_q;
	logic        od_mode;

	assign od_mode = seq_q inside {S_OD_RD, S_CAP, S_OD_HI, S_OD_LO, S_OD_DRAIN} && !ret_rd_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			od_start_q <= '0;
			od_len_q   <= '0;
			bm_rdata   <= '0;
		end else if (ce) begin
			if (bm_wr && bm_addr == `PLC_BM_OD_START) begin
				od_start_q <= bm_wdata;
			end
			if (bm_wr && bm_addr == `PLC_BM_OD_LEN) begin
				od_len_q <= bm_wdata;
			end
			if (bm_rd) begin
				case (bm_addr)
					`PLC_BM_OD_START: bm_rdata <= od_start_q;
					`PLC_BM_OD_LEN:   bm_rdata <= od_len_q;
					`PLC_BM_OD_ERR:   bm_rdata <= od_err_q;
					default:          bm_rdata <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			od_err_q <= `PLC_OD_ERR_NONE;
		end else if (ce) begin
			if (od_mode && tx_error) begin
				od_err_q <= `PLC_OD_ERR_SET;
			end else if (bm_wr && bm_addr == `PLC_BM_OD_ERR) begin
				od_err_q <= bm_wdata;
			end else if (seq_q == S_IDLE && ondemand_busy_flag && (full_q || !rx_act_q)) begin
				od_err_q <= `PLC_OD_ERR_NONE;
			end
		end
	end

	// ****************************************
	// transmit sequencer
	// ****************************************
	plc_fifo_if #(.W(`PLC_FIFO_W)) fq ();
	logic [15:0] odn_q;
	logic [7:0]  idx_q;
	logic [15:0] hold_q;
	logic        head_last;

	assign head_last    = (err_q != `PLC_RSP_OK) || op_q == OP_WR || cnt_q == 8'h00;
	// reply done once its final byte enters the fifo
	assign resp_take    = ce && fq.in_ready && ((seq_q == S_HEAD && head_last)
	                      || (seq_q inside {S_RDPUSH, S_ECHO} && idx_q == 8'(cnt_q - 1'b1)));
	assign fq.out_ready = tx_ready;
	assign tx_valid     = fq.out_valid;
	assign {tx_last, tx_data} = fq.out_data;

	always_comb begin
		fq.in_valid = 1'b0;
		fq.in_data  = '0;
		case (seq_q)
			S_OD_HI:   begin fq.in_valid = 1'b1; fq.in_data = {1'b0, hold_q[15:8]}; end
			S_OD_LO:   begin fq.in_valid = 1'b1; fq.in_data = {odn_q == 16'h1, hold_q[7:0]}; end
			S_HEAD:    begin fq.in_valid = 1'b1; fq.in_data = {head_last, err_q}; end
			S_RDPUSH:  begin fq.in_valid = 1'b1; fq.in_data = {idx_q == 8'(cnt_q - 1'b1), hold_q[7:0]}; end
			S_ECHO:    begin fq.in_valid = 1'b1; fq.in_data = {idx_q == 8'(cnt_q - 1'b1), buf_q[idx_q]}; end
			default:   begin fq.in_valid = 1'b0; fq.in_data = '0; end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seq_q              <= S_IDLE;
			odn_q              <= '0;
			idx_q              <= '0;
			hold_q             <= '0;
			ret_rd_q           <= 1'b0;
			ondemand_busy_flag <= 1'b0;
			mem_rd             <= 1'b0;
			mem_we             <= 1'b0;
			mem_space          <= `PLC_SP_MICRO_MAIN;
			mem_addr           <= '0;
			mem_wdata          <= '0;
		end else if (ce) begin
			mem_rd <= 1'b0;
			mem_we <= 1'b0;
			if (od_request) begin
				ondemand_busy_flag <= 1'b1;
			end
			case (seq_q)
				S_IDLE: begin
					idx_q <= '0;
					odn_q <= od_len_q;
					if (ondemand_busy_flag && (full_q || !rx_act_q)) begin
						seq_q    <= (od_len_q == 16'h0) ? S_OD_DRAIN : S_OD_RD;
						ret_rd_q <= 1'b0;
					end else if (done_q) begin
						seq_q <= (err_q == `PLC_RSP_OK && op_q == OP_WR) ? S_WR : S_HEAD;
					end
				end
				S_OD_RD: begin
					mem_rd    <= 1'b1;
					mem_space <= `PLC_SP_BUF;
					mem_addr  <= 20'(od_start_q) + 20'(16'(od_len_q - odn_q));
					seq_q     <= S_CAP;
				end
				S_CAP: begin
					if (!mem_rd) begin
						hold_q <= mem_rdata;
						seq_q  <= ret_rd_q ? S_RDPUSH : S_OD_HI;
					end
				end
				S_OD_HI: if (fq.in_ready) begin
					seq_q <= S_OD_LO;
				end
				S_OD_LO: if (fq.in_ready) begin
					odn_q <= 16'(odn_q - 1'b1);
					seq_q <= (odn_q == 16'h1) ? S_OD_DRAIN : S_OD_RD;
				end
				S_OD_DRAIN: if (!fq.out_valid) begin
					ondemand_busy_flag <= 1'b0;
					seq_q              <= S_IDLE;
				end
				S_WR: begin
					mem_we    <= 1'b1;
					mem_space <= space_q;
					mem_addr  <= addr_q + 20'(idx_q);
					mem_wdata <= buf_q[idx_q];
					idx_q     <= 8'(idx_q + 1'b1);
					if (idx_q == 8'(cnt_q - 1'b1)) begin
						seq_q <= S_HEAD;
					end
				end
				S_HEAD: if (fq.in_ready) begin
					idx_q    <= '0;
					ret_rd_q <= 1'b1;
					if (head_last) begin
						seq_q <= S_IDLE;
					end else begin
						seq_q <= (op_q == OP_ECHO) ? S_ECHO : S_RD;
					end
				end
				S_RD: begin
					mem_rd    <= 1'b1;
					mem_space <= space_q;
					mem_addr  <= addr_q + 20'(idx_q);
					seq_q     <= S_CAP;
				end
				S_RDPUSH: if (fq.in_ready) begin
					idx_q <= 8'(idx_q + 1'b1);
					seq_q <= (idx_q == 8'(cnt_q - 1'b1)) ? S_IDLE : S_RD;
				end
				S_ECHO: if (fq.in_ready) begin
					idx_q <= 8'(idx_q + 1'b1);
					seq_q <= (idx_q == 8'(cnt_q - 1'b1)) ? S_IDLE : S_ECHO;
				end
				default: seq_q <= S_IDLE;
			endcase
		end
	end

	plc_fifo #(.W(`PLC_FIFO_W), .D(`PLC_FIFO_D)) u_fifo (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.f   (fq)
	);

	// ****************************************
	// checks
	// ****************************************
	a_busy_rise: assert property (@(posedge clk) disable iff (rst)
		ce && od_request |=> ondemand_busy_flag) else $error("busy flag did not rise");
	a_ext_reject: assert property (@(posedge clk) disable iff (rst)
		mem_we && mem_space == `PLC_SP_EXT |-> err_q == `PLC_RSP_OK) else $error("refused write done");
	a_global_quiet: assert property (@(posedge clk) disable iff (rst)
		!(done_q && op_q == OP_GLOBAL)) else $error("reply queued for broadcast");
	a_od_err_set: assert property (@(posedge clk) disable iff (rst)
		ce && od_mode && tx_error |=> od_err_q == `PLC_OD_ERR_SET) else $error("error word not set");
	a_od_half_hold: assert property (@(posedge clk) disable iff (rst)
		ce && seq_q == S_IDLE && !full_q && rx_act_q |=> !(seq_q inside {S_OD_RD, S_OD_DRAIN}))
		else $error("send started during command on half duplex");
	a_reply_defer: assert property (@(posedge clk) disable iff (rst)
		ce && seq_q == S_IDLE && ondemand_busy_flag && done_q && (full_q || !rx_act_q)
		|=> seq_q inside {S_OD_RD, S_OD_DRAIN}) else $error("reply not deferred");
	a_micro_range: assert property (@(posedge clk) disable iff (rst)
		mem_rd && mem_space inside {`PLC_SP_MICRO_MAIN, `PLC_SP_MICRO_SUB}
		|-> mem_addr < 20'(micro_cap)) else $error("program read past capacity");
	a_echo_limit: assert property (@(posedge clk) disable iff (rst)
		seq_q == S_ECHO |-> cnt_q <= `PLC_MAX_ECHO && err_q == `PLC_RSP_OK)
		else $error("echo beyond limit");
	a_wr_count: assert property (@(posedge clk) disable iff (rst)
		mem_we |-> cnt_q <= `PLC_MAX_BYTES ##1 !(mem_we && seq_q == S_IDLE))
		else $error("write count exceeded");
endmodule
`default_nettype wire

/* File: inc/plc_link_map.svh */
`ifndef PLC_LINK_MAP_SVH
`define PLC_LINK_MAP_SVH

// first command letters
`define PLC_CH_MICRO_MAIN 8'h55
`define PLC_CH_MICRO_SUB  8'h56
`define PLC_CH_COMMENT    8'h4b
`define PLC_CH_EXT        8'h44
`define PLC_CH_GLOBAL     8'h47
`define PLC_CH_ECHO       8'h54
// second command letters and global flag characters
`define PLC_CH_READ       8'h52
`define PLC_CH_WRITE      8'h57
`define PLC_CH_ZERO       8'h30
`define PLC_CH_ONE        8'h31

// answers
`define PLC_RSP_OK        8'h00
`define PLC_RSP_AREA_ERR  8'h06
`define PLC_RSP_REJECT    8'h07

// limits
`define PLC_MAX_BYTES     8'h80
`define PLC_MAX_ECHO      8'hfe
`define PLC_EXT_ADDR_MAX  20'h0fbff
`define PLC_DIG_SHORT     3'h4
`define PLC_DIG_LONG      3'h5
`define PLC_DIG_CNT       3'h2
`define PLC_STN_ALL       8'h00

// buffer memory words
`define PLC_BM_OD_START   12'h109
`define PLC_BM_OD_LEN     12'h10a
`define PLC_BM_OD_ERR     12'h10c
`define PLC_OD_ERR_SET    16'h0001
`define PLC_OD_ERR_NONE   16'h0000

// memory spaces on the memory port
`define PLC_SP_MICRO_MAIN 3'h0
`define PLC_SP_MICRO_SUB  3'h1
`define PLC_SP_COMMENT    3'h2
`define PLC_SP_EXT        3'h3
`define PLC_SP_BUF        3'h4

`define PLC_FIFO_W        9
`define PLC_FIFO_D        8

`endif

/* File: inc/plc_link_pkg.sv */
package plc_link_pkg;
	typedef enum logic [2:0] {P_STN, P_CMD, P_ADDR, P_CNT, P_DATA, P_GFLAG, P_SKIP} plc_pst_t;
	typedef enum logic [2:0] {OP_NONE, OP_RD, OP_WR, OP_ECHO, OP_GLOBAL} plc_op_t;
	typedef enum logic [3:0] {S_IDLE, S_OD_RD, S_CAP, S_OD_HI, S_OD_LO, S_OD_DRAIN,
		S_HEAD, S_WR, S_RD, S_RDPUSH, S_ECHO} plc_seq_t;
endpackage

/* File: inc/plc_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface plc_fifo_if #(parameter int W = 9);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;
	modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

/* File: hdl/plc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module plc_fifo #(
	parameter int W = 9,
	parameter int D = 8
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	plc_fifo_if.fifo  f
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  store [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic          oval_q;
	logic [W-1:0]  odat_q;
	logic          push;
	logic          pop;

	// ****************************************
	// storage plus registered output stage
	// ****************************************
	assign f.in_ready  = (cnt_q != (AW+1)'(D));
	assign push        = f.in_valid && f.in_ready;
	assign pop         = (cnt_q != '0) && (!oval_q || f.out_ready);
	assign f.out_valid = oval_q;
	assign f.out_data  = odat_q;

	always_ff @(posedge clk) begin
		if (ce && push) begin
			store[wr_q] <= f.in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			if (push) begin
				wr_q <= AW'(wr_q + 1'b1);
			end
			if (pop) begin
				rd_q <= AW'(rd_q + 1'b1);
			end
			cnt_q <= (AW+1)'(cnt_q + push - pop);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oval_q <= 1'b0;
			odat_q <= '0;
		end else if (ce) begin
			if (pop) begin
				oval_q <= 1'b1;
				odat_q <= store[rd_q];
			end else if (f.out_ready) begin
				oval_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verif/plc_link_host.sv */
`timescale 1ns/1ps
`default_nettype none
module plc_link_host (
	input  wire logic       clk,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_last,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	output logic            tx_ready
);
	logic [8:0] got[$];
	logic       slow;
	// ****************************************
	// frames toward the block
	// ****************************************
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_last = 1'b0;
		tx_ready = 1'b0;
		slow = 1'b0;
	end
	// addresses and counts go as ascii hex digits
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(negedge clk);
			rx_valid = 1'b1;
			rx_data = s[i];
			rx_last = (i == s.len() - 1);
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_last = 1'b0;
		rx_data = ~rx_data;
	endtask
	// ****************************************
	// replies, optionally stalled
	// ****************************************
	always @(negedge clk) begin
		tx_ready = slow ? ~tx_ready : 1'b1;
	end
	// capture each reply byte on a cycle with tx_valid and tx_ready both high
	always @(posedge clk) begin
		if (tx_valid === 1'b1 && tx_ready)
			got.push_back({tx_last, tx_data});
	end
endmodule
`default_nettype wire

/* File: verif/plc_link_command_handler_test.sv */
`timescale 1ns/1ps
`default_nettype none
module plc_link_command_handler_test;
	logic        clk, rst, ce, rx_valid, rx_last, tx_valid, tx_last, tx_ready, tx_error;
	logic [7:0]  rx_data, tx_data, station_pin, mem_wdata, wd;
	logic        full_duplex_pin, cpu_running_pin, run_write_permit_switch;
	logic [16:0] micro_cap, comment_cap, ext_cap;
	logic        mem_rd, mem_we, bm_wr, bm_rd, od_request;
	logic [2:0]  mem_space, ws;
	logic [19:0] mem_addr, wa;
	logic [15:0] mem_rdata, bm_wdata, bm_rdata;
	logic [11:0] bm_addr;
	logic        global_input_flag, ondemand_busy_flag;
	int          err_count, compares;

	plc_link_cmd DUT (.clk, .rst, .ce, .rx_valid, .rx_data, .rx_last, .tx_valid, .tx_data,
		.tx_last, .tx_ready, .tx_error, .full_duplex_pin, .cpu_running_pin,
		.run_write_permit_switch, .station_pin, .micro_cap, .comment_cap, .ext_cap,
		.mem_rd, .mem_we, .mem_space, .mem_addr, .mem_wdata, .mem_rdata, .bm_addr, .bm_wr,
		.bm_rd, .bm_wdata, .bm_rdata, .od_request, .global_input_flag, .ondemand_busy_flag);
	plc_link_host host (.clk, .rx_valid, .rx_data, .rx_last, .tx_valid, .tx_data, .tx_last,
		.tx_ready);

	// ****************************************
	// clock and memory model
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	assign mem_rdata = {~mem_addr[7:0], mem_addr[7:0] ^ 8'h3c};
	always @(posedge clk) begin
		if (mem_we === 1'b1) begin
			wa <= mem_addr;
			wd <= mem_wdata;
			ws <= mem_space;
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic summarize();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bm(input logic [11:0] a, input logic w, input logic [15:0] d);
		@(negedge clk);
		bm_addr = a;
		bm_wr = w;
		bm_rd = !w;
		bm_wdata = d;
		@(negedge clk);
		bm_wr = 1'b0;
		bm_rd = 1'b0;
	endtask
	// wait for k reply bytes, then compare them all
	task automatic expect_got(input logic [7:0] e[$], input int cut = -1);
		int n;
		n = 0;
		while (host.got.size() < e.size() && n < 400) begin
			@(negedge clk);
			n++;
		end
		if (n == 400) begin
			err_count++;
			summarize();
		end
		repeat (20) @(negedge clk);
		chk(host.got.size(), e.size());
		if (host.got.size() == e.size())
			foreach (e[i]) chk(host.got[i], {i == e.size() - 1 || i == cut, e[i]});
		host.got.delete();
	endtask
	// cut: index of a byte that closes an earlier frame in the list
	task automatic xfer(input string f, input logic [7:0] e[$]);
		host.send(f);
		expect_got(e);
	endtask
	task automatic od_pulse();
		@(negedge clk);
		od_request = 1'b1;
		@(negedge clk);
		od_request = 1'b0;
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		{rst, ce, tx_error, bm_wr, bm_rd, od_request} = 6'b110000;
		{full_duplex_pin, cpu_running_pin, run_write_permit_switch} = 3'b100;
		{bm_addr, bm_wdata, station_pin} = '0;
		station_pin = 8'h01;
		micro_cap = 17'h00100;
		comment_cap = 17'h00040;
		ext_cap = 17'h00010;
		err_count = 0;
		compares = 0;
		repeat (8) @(negedge clk);
		chk({global_input_flag, ondemand_busy_flag, tx_valid}, 16'h0000);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		bm(12'h109, 1'b1, 16'h0030);
		bm(12'h10a, 1'b1, 16'h0001);
		bm(12'h109, 1'b0, 16'h0000);
		chk(bm_rdata, 16'h0030);
		bm(12'h10b, 1'b0, 16'h0000);
		chk(bm_rdata, 16'h0000);
		xfer("01UR001001", '{8'h00, 8'h2c});
		xfer("01VR000001", '{8'h00, 8'h3c});
		xfer("01UR00FF01", '{8'h00, 8'hc3});
		xfer("01UR00FF02", '{8'h06});
		xfer("01UW002001A5", '{8'h00});
		chk({wa[15:0]}, 16'h0020);
		chk({8'h00, wd}, 16'h00a5);
		chk(ws, 16'h0000);
		xfer("01VW000101A5", '{8'h00});
		chk(wa[15:0], 16'h0001);
		chk(ws, 16'h0001);
		xfer("01KR000002", '{8'h00, 8'h3c, 8'h3d});
		xfer("01KW003E02A5A5", '{8'h00});
		chk(wa[15:0], 16'h003f);
		chk(ws, 16'h0002);
		xfer("01KR003F02", '{8'h06});
		xfer("01DR0000001", '{8'h00, 8'h3c});
		xfer("01DR0001002", '{8'h06});
		xfer("01DW0000001A5", '{8'h00});
		chk(ws, 16'h0003);
		cpu_running_pin = 1'b1;
		xfer("01DW0000001A5", '{8'h07});
		xfer("01TT02AB", '{8'h00, 8'h41, 8'h42});
		xfer("01TTFF", '{8'h06});
		xfer("02UR001001", '{});
		xfer("00GW1", '{});
		chk(global_input_flag, 16'h0001);
		xfer("02GW0", '{});
		chk(global_input_flag, 16'h0001);
		xfer("01GW0", '{});
		chk(global_input_flag, 16'h0000);
		// on-demand alone, then with a stalled line and a line error
		od_pulse();
		chk(ondemand_busy_flag, 16'h0001);
		expect_got('{8'hcf, 8'h0c});
		chk(ondemand_busy_flag, 16'h0000);
		bm(12'h10c, 1'b0, 16'h0000);
		chk(bm_rdata, 16'h0000);
		host.slow = 1'b1;
		od_pulse();
		@(negedge clk);
		tx_error = 1'b1;
		@(negedge clk);
		tx_error = 1'b0;
		expect_got('{8'hcf, 8'h0c});
		bm(12'h10c, 1'b0, 16'h0000);
		chk(bm_rdata, 16'h0001);
		// request during a reply: reply first
		host.send("01TT04ABCD");
		for (int n = 0; n < 400 && host.got.size() == 0; n++)
			@(negedge clk);
		if (host.got.size() == 0) begin
			err_count++;
			summarize();
		end
		od_pulse();
		expect_got('{8'h00, 8'h41, 8'h42, 8'h43, 8'h44, 8'hcf, 8'h0c}, 4);
		host.slow = 1'b0;
		// request while a command arrives on half duplex: send first
		full_duplex_pin = 1'b0;
		repeat (3) @(negedge clk);
		fork
			host.send("01UR001001");
			begin
				repeat (3) @(negedge clk);
				od_pulse();
			end
		join
		expect_got('{8'hcf, 8'h0c, 8'h00, 8'h2c}, 1);
		xfer("00GW1", '{});
		rst = 1'b1;
		@(negedge clk);
		chk(global_input_flag, 16'h0000);
		summarize();
	end
endmodule
`default_nettype wire
